// ===== common/pmsc_pkg.sv
// Shared constants of the transceiver mode, strap and mirror control block.
// Assumes a single 250 MHz core clock and a management port of 16-bit words.
package pmsc_pkg;

	// Management register offsets
	localparam logic [7:0] ADDR_MODE_CONFIG_ONE  = 8'h09;
	localparam logic [7:0] ADDR_INT_MASK_CONTROL = 8'h12;
	localparam logic [7:0] ADDR_INT_STATUS       = 8'h13;
	localparam logic [7:0] ADDR_MODE_CONFIG_FOUR = 8'h31;

	// mode_config_one fields
	localparam int TEST_MODE_LSB = 13;
	localparam int TEST_MODE_MSB = 15;

	// mode_config_four fields
	localparam int MIRROR_BIT    = 0;
	localparam int TX_SKEW_LSB   = 1;
	localparam int TX_SKEW_MSB   = 2;
	localparam int RX_SKEW_LSB   = 3;
	localparam int RX_SKEW_MSB   = 5;
	localparam int ANEG_DIS_BIT  = 7;
	localparam int DS_EN_BIT     = 8;
	localparam int DS_ENH_BIT    = 9;
	localparam int DS_CNT_LSB    = 10;
	localparam int DS_CNT_MSB    = 12;

	// Interrupt status and mask bit positions
	localparam int INT_LINK_BIT  = 0;
	localparam int INT_SPEED_BIT = 1;
	localparam int INT_DS_BIT    = 2;
	localparam int INT_WIDTH     = 3;

	// Reset values
	localparam logic [2:0]  DS_CNT_DEFAULT = 3'h4;
	localparam logic [2:0]  TEST_NORMAL    = 3'h0;
	localparam logic [2:0]  TEST_MODE_MAX  = 3'h4;
	localparam logic [15:0] REG_ZERO       = 16'h0000;

	// Four-level strap mode codes as delivered by the level comparators
	localparam logic [1:0] STRAP_MODE1 = 2'h0;
	localparam logic [1:0] STRAP_MODE2 = 2'h1;
	localparam logic [1:0] STRAP_MODE3 = 2'h2;
	localparam logic [1:0] STRAP_MODE4 = 2'h3;
	localparam int         STRAP_COUNT = 7;

	// Strap settle time before the one-shot capture
	localparam int CLK_PERIOD_PS     = 4000;
	localparam int STRAP_SETTLE_NS   = 40;
	localparam int STRAP_SETTLE_CYC  = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] SETTLE_LAST = 4'(STRAP_SETTLE_CYC - 1);

	// Test pattern symbol levels (three-bit signed line symbols)
	localparam logic [2:0] SYM_POS2 = 3'h2;
	localparam logic [2:0] SYM_NEG2 = 3'h6;
	localparam logic [2:0] SYM_ZERO = 3'h0;
	localparam logic [10:0] LFSR_SEED = 11'h7ff;

	typedef enum logic [1:0] {
		PMSC_SPD_10,
		PMSC_SPD_100,
		PMSC_SPD_1000
	} pmsc_speed_e;

endpackage

// ===== verilog/pmsc_strap_sync.sv
// Three-stage synchroniser for one four-level strap mode code.
// Assumes the comparator output is asynchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module pmsc_strap_sync (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_ce,
	input  wire logic [1:0] i_mode_async,
	output logic      [1:0] o_mode
);

	logic [1:0] meta_reg;
	logic [1:0] stage2_reg;
	logic [1:0] stage3_reg;

	// Only stage two and three are compared; the first flop feeds stage two alone
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_reg   <= pmsc_pkg::STRAP_MODE1;
			stage2_reg <= pmsc_pkg::STRAP_MODE1;
			stage3_reg <= pmsc_pkg::STRAP_MODE1;
			o_mode     <= pmsc_pkg::STRAP_MODE1;
		end else if (i_ce) begin
			meta_reg   <= i_mode_async;
			stage2_reg <= meta_reg;
			stage3_reg <= stage2_reg;
			if (stage2_reg == stage3_reg) begin
				o_mode <= stage3_reg; // Filters a one-cycle glitch
			end
		end
	end

endmodule
`default_nettype wire

// ===== verilog/pmsc_top.sv
// Mode control of a tri-speed copper transceiver: strap capture, downshift,
// mirroring with polarity reversal, compliance test patterns, status interrupt.
// Assumes straps arrive as two-bit comparator codes, line symbols are three-bit
// signed values and the management port delivers decoded word accesses.
//
// Summary of operation
// - With downshift on, repeated gigabit link failures drop the speed to 100 Mb/s.
// - Failure count before downshift is programmable, four after reset.
// - Enhanced mode drops after one failure when channels C and D are silent.
// - Failure at both gigabit and 100 Mb/s falls back to 10 Mb/s.
// - Downshift stays off until software enables it.
// - Mirroring at 10/100 maps A to D and B to C for either pairing.
// - Mirroring at gigabit swaps A with D and B with C.
// - Mirroring is enabled by strap or by the mirror bit at 0x31.
// - Mirrored channels also have their polarity inverted.
// - Masked status changes at 0x13 raise the interrupt, selected at 0x12.
// - Register 0x09 selects normal operation or one of four test modes.
// - Test modes drive the pattern on media and a synchronous clock out.
// - Strap pins are captured at power-up or hardware reset and held.
// - Software reset reloads strap settings from the captured values only.
// - Every strap option except the management address is also settable by register.
// - Second general pin strap modes 1 to 4 give rx skew [2:1] 00 to 11.
// - First general pin strap gives rx skew bit 0: mode 1 zero, mode 3 one.
// - Third indicator strap modes 1 to 4 give tx skew [1:0] 00 to 11.
// - Two receive data straps form a four-bit management address, default 0.
// - Receive control strap modes 3 and 4 give autoneg disable 0 and 1.
`timescale 1ns/10ps
`default_nettype none
module pmsc_top (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_ce,
	input  wire logic       i_sw_reset,
	input  wire logic [1:0] i_rx_data_lane0_strap,
	input  wire logic [1:0] i_rx_data_lane2_strap,
	input  wire logic [1:0] i_rx_ctrl_strap,
	input  wire logic [1:0] i_gp0_strap,
	input  wire logic [1:0] i_gp1_strap,
	input  wire logic [1:0] i_indicator2_strap,
	input  wire logic [1:0] i_indicator0_strap,
	input  wire logic       i_mgmt_wr,
	input  wire logic       i_mgmt_rd,
	input  wire logic [7:0] i_mgmt_addr,
	input  wire logic [15:0] i_mgmt_wdata,
	output logic      [15:0] o_mgmt_rdata,
	output logic            o_mgmt_rvalid,
	input  wire logic       i_link_fail,
	input  wire logic       i_link_up,
	input  wire logic       i_energy_cd,
	input  wire logic       i_mdix,
	input  wire logic [2:0] i_tx_sym_a,
	input  wire logic [2:0] i_tx_sym_b,
	input  wire logic [2:0] i_tx_sym_c,
	input  wire logic [2:0] i_tx_sym_d,
	output logic      [2:0] o_mdi_sym_a,
	output logic      [2:0] o_mdi_sym_b,
	output logic      [2:0] o_mdi_sym_c,
	output logic      [2:0] o_mdi_sym_d,
	output logic            o_clk_out,
	output logic      [1:0] o_speed,
	output logic      [3:0] o_mgmt_addr,
	output logic      [2:0] o_rx_skew,
	output logic      [1:0] o_tx_skew,
	output logic            o_aneg_disable,
	output logic            o_mirror_active,
	output logic            o_int_n
);

	// Synchronised strap codes, one slot per pin
	logic [1:0] strap_async [pmsc_pkg::STRAP_COUNT];
	logic [1:0] strap_sync  [pmsc_pkg::STRAP_COUNT];
	logic [1:0] latch_reg   [pmsc_pkg::STRAP_COUNT];
	logic [3:0] settle_reg;
	logic       captured_reg;
	logic       strap_load_reg;

	logic [15:0] cfg_one_reg;
	logic [15:0] cfg_four_reg;
	logic [15:0] cfg_four_strap;
	logic [pmsc_pkg::INT_WIDTH-1:0] int_mask_reg;
	logic [pmsc_pkg::INT_WIDTH-1:0] int_stat_reg;
	logic [pmsc_pkg::INT_WIDTH-1:0] int_event;
	logic [pmsc_pkg::INT_WIDTH-1:0] stat_clear;

	pmsc_pkg::pmsc_speed_e speed_reg;
	pmsc_pkg::pmsc_speed_e speed_next;
	logic [2:0] fail_cnt_reg;
	logic       link_up_reg;
	logic       ds_event;
	logic       mirror_en;
	logic [2:0] test_mode;
	logic [10:0] lfsr_reg;
	logic       test_phase_reg;
	logic [2:0] pattern_sym;

	assign strap_async[0] = i_rx_data_lane0_strap;
	assign strap_async[1] = i_rx_data_lane2_strap;
	assign strap_async[2] = i_rx_ctrl_strap;
	assign strap_async[3] = i_gp0_strap;
	assign strap_async[4] = i_gp1_strap;
	assign strap_async[5] = i_indicator2_strap;
	assign strap_async[6] = i_indicator0_strap;

	// One synchroniser per strap pin
	for (genvar g = 0; g < pmsc_pkg::STRAP_COUNT; g++) begin : g_sync
		pmsc_strap_sync u_sync (
			.i_clk       (i_clk),
			.i_arst_n    (i_arst_n),
			.i_ce        (i_ce),
			.i_mode_async(strap_async[g]),
			.o_mode      (strap_sync[g])
		);
	end

	// Receive clock skew bit 0 only has meaning in modes 1 and 3
	function automatic logic gp0_skew(input logic [1:0] mode);
		gp0_skew = (mode == pmsc_pkg::STRAP_MODE3);
	endfunction

	// Autoneg disable only defined in modes 3 and 4
	function automatic logic aneg_decode(input logic [1:0] mode);
		aneg_decode = (mode == pmsc_pkg::STRAP_MODE4);
	endfunction

	// Negation of a three-bit signed line symbol
	function automatic logic [2:0] invert_sym(input logic [2:0] sym);
		invert_sym = 3'(~sym + 3'h1);
	endfunction

	// Capture straps once after hardware reset, when the synchronisers settle
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			settle_reg   <= 4'h0;
			captured_reg <= 1'b0;
			strap_load_reg <= 1'b0;
			for (int i = 0; i < pmsc_pkg::STRAP_COUNT; i++) begin
				latch_reg[i] <= pmsc_pkg::STRAP_MODE1;
			end
		end else if (i_ce) begin
			strap_load_reg <= 1'b0;
			if (!captured_reg && settle_reg == pmsc_pkg::SETTLE_LAST) begin
				captured_reg   <= 1'b1;
				strap_load_reg <= 1'b1; // Image is built from the fresh latch next edge
				for (int i = 0; i < pmsc_pkg::STRAP_COUNT; i++) begin
					latch_reg[i] <= strap_sync[i];
				end
			end else if (!captured_reg) begin
				settle_reg <= 4'(settle_reg + 4'h1);
			end
		end
	end

	// Strap image of mode_config_four; downshift fields keep software defaults
	always_comb begin
		cfg_four_strap = pmsc_pkg::REG_ZERO;
		cfg_four_strap[pmsc_pkg::MIRROR_BIT] = latch_reg[6][1];
		cfg_four_strap[pmsc_pkg::TX_SKEW_MSB:pmsc_pkg::TX_SKEW_LSB] = latch_reg[5];
		cfg_four_strap[pmsc_pkg::RX_SKEW_MSB:pmsc_pkg::RX_SKEW_LSB] =
			{latch_reg[4], gp0_skew(latch_reg[3])};
		cfg_four_strap[pmsc_pkg::ANEG_DIS_BIT] = aneg_decode(latch_reg[2]);
		cfg_four_strap[pmsc_pkg::DS_CNT_MSB:pmsc_pkg::DS_CNT_LSB] = pmsc_pkg::DS_CNT_DEFAULT;
	end

	// Configuration registers: strap image into 0x31 and zero into 0x09 on capture or software reset, else writes; 0x12 only by writes
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_four_reg <= pmsc_pkg::REG_ZERO;
			cfg_four_reg[pmsc_pkg::DS_CNT_MSB:pmsc_pkg::DS_CNT_LSB] <= pmsc_pkg::DS_CNT_DEFAULT;
			cfg_one_reg  <= pmsc_pkg::REG_ZERO;
			int_mask_reg <= '0;
		end else if (i_ce) begin
			if (i_sw_reset || strap_load_reg) begin
				cfg_four_reg <= cfg_four_strap;
				cfg_one_reg  <= pmsc_pkg::REG_ZERO;
			end else if (i_mgmt_wr) begin
				if (i_mgmt_addr == pmsc_pkg::ADDR_MODE_CONFIG_FOUR) begin
					cfg_four_reg <= i_mgmt_wdata;
				end
				if (i_mgmt_addr == pmsc_pkg::ADDR_MODE_CONFIG_ONE) begin
					cfg_one_reg <= i_mgmt_wdata;
				end
				if (i_mgmt_addr == pmsc_pkg::ADDR_INT_MASK_CONTROL) begin
					int_mask_reg <= i_mgmt_wdata[pmsc_pkg::INT_WIDTH-1:0];
				end
			end
		end
	end

	// Reserved test codes above four fall back to normal operation
	assign test_mode = (cfg_one_reg[pmsc_pkg::TEST_MODE_MSB:pmsc_pkg::TEST_MODE_LSB]
		> pmsc_pkg::TEST_MODE_MAX) ? pmsc_pkg::TEST_NORMAL :
		cfg_one_reg[pmsc_pkg::TEST_MODE_MSB:pmsc_pkg::TEST_MODE_LSB];
	assign mirror_en = cfg_four_reg[pmsc_pkg::MIRROR_BIT];

	// Downshift speed choice on each reported gigabit or 100M failure
	always_comb begin
		speed_next = speed_reg;
		ds_event   = 1'b0;
		if (!cfg_four_reg[pmsc_pkg::DS_EN_BIT]) begin
			speed_next = pmsc_pkg::PMSC_SPD_1000;
		end else if (i_link_fail) begin
			case (speed_reg)
				pmsc_pkg::PMSC_SPD_1000: begin
					if ((cfg_four_reg[pmsc_pkg::DS_ENH_BIT] && !i_energy_cd) ||
						(3'(fail_cnt_reg + 3'h1) >=
						cfg_four_reg[pmsc_pkg::DS_CNT_MSB:pmsc_pkg::DS_CNT_LSB])) begin
						speed_next = pmsc_pkg::PMSC_SPD_100;
						ds_event   = 1'b1;
					end
				end
				pmsc_pkg::PMSC_SPD_100: begin
					speed_next = pmsc_pkg::PMSC_SPD_10;
					ds_event   = 1'b1;
				end
				pmsc_pkg::PMSC_SPD_10: begin
					speed_next = pmsc_pkg::PMSC_SPD_10;
				end
				default: begin
					speed_next = pmsc_pkg::PMSC_SPD_1000;
				end
			endcase
		end
	end

	// Speed state and consecutive failure count; a good link clears the count
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			speed_reg    <= pmsc_pkg::PMSC_SPD_1000;
			fail_cnt_reg <= 3'h0;
		end else if (i_ce) begin
			speed_reg <= i_sw_reset ? pmsc_pkg::PMSC_SPD_1000 : speed_next;
			if (i_sw_reset || i_link_up || speed_next != speed_reg ||
				!cfg_four_reg[pmsc_pkg::DS_EN_BIT]) begin
				fail_cnt_reg <= 3'h0;
			end else if (i_link_fail && speed_reg == pmsc_pkg::PMSC_SPD_1000 &&
				fail_cnt_reg != 3'h7) begin
				fail_cnt_reg <= 3'(fail_cnt_reg + 3'h1);
			end
		end
	end

	// Test pattern source; the LFSR stands in for the scrambled pattern of mode four
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lfsr_reg       <= pmsc_pkg::LFSR_SEED;
			test_phase_reg <= 1'b0;
		end else if (i_ce) begin
			if (test_mode == pmsc_pkg::TEST_NORMAL) begin
				lfsr_reg       <= pmsc_pkg::LFSR_SEED;
				test_phase_reg <= 1'b0;
			end else begin
				lfsr_reg       <= {lfsr_reg[9:0], lfsr_reg[10] ^ lfsr_reg[8]};
				test_phase_reg <= ~test_phase_reg;
			end
		end
	end

	always_comb begin
		case (test_mode)
			3'h4:    pattern_sym = lfsr_reg[10] ? pmsc_pkg::SYM_POS2 : pmsc_pkg::SYM_NEG2;
			3'h0:    pattern_sym = pmsc_pkg::SYM_ZERO;
			default: pattern_sym = test_phase_reg ? pmsc_pkg::SYM_POS2 : pmsc_pkg::SYM_NEG2;
		endcase
	end

	// Media symbol steering; mirroring and inversion ignore MDI/MDIX on purpose
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mdi_sym_a <= pmsc_pkg::SYM_ZERO;
			o_mdi_sym_b <= pmsc_pkg::SYM_ZERO;
			o_mdi_sym_c <= pmsc_pkg::SYM_ZERO;
			o_mdi_sym_d <= pmsc_pkg::SYM_ZERO;
			o_clk_out   <= 1'b0;
		end else if (i_ce) begin
			o_clk_out <= test_phase_reg;
			if (test_mode != pmsc_pkg::TEST_NORMAL) begin
				o_mdi_sym_a <= pattern_sym;
				o_mdi_sym_b <= pattern_sym;
				o_mdi_sym_c <= pattern_sym;
				o_mdi_sym_d <= pattern_sym;
			end else if (!mirror_en) begin
				o_mdi_sym_a <= i_tx_sym_a;
				o_mdi_sym_b <= i_tx_sym_b;
				o_mdi_sym_c <= i_tx_sym_c;
				o_mdi_sym_d <= i_tx_sym_d;
			end else if (speed_reg == pmsc_pkg::PMSC_SPD_1000) begin
				o_mdi_sym_a <= invert_sym(i_tx_sym_d);
				o_mdi_sym_b <= invert_sym(i_tx_sym_c);
				o_mdi_sym_c <= invert_sym(i_tx_sym_b);
				o_mdi_sym_d <= invert_sym(i_tx_sym_a);
			end else begin
				o_mdi_sym_a <= pmsc_pkg::SYM_ZERO;
				o_mdi_sym_b <= pmsc_pkg::SYM_ZERO;
				o_mdi_sym_c <= invert_sym(i_tx_sym_b);
				o_mdi_sym_d <= invert_sym(i_tx_sym_a);
			end
		end
	end

	// Status events: link change, speed change, downshift
	always_comb begin
		int_event = '0;
		int_event[pmsc_pkg::INT_LINK_BIT]  = (i_link_up != link_up_reg);
		int_event[pmsc_pkg::INT_SPEED_BIT] = (speed_next != speed_reg);
		int_event[pmsc_pkg::INT_DS_BIT]    = ds_event;
		stat_clear = (i_mgmt_rd && i_mgmt_addr == pmsc_pkg::ADDR_INT_STATUS) ?
			{pmsc_pkg::INT_WIDTH{1'b1}} : '0;
	end

	// Sticky status, cleared by reading; a same-cycle event survives the clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			int_stat_reg <= '0;
			link_up_reg  <= 1'b0;
			o_int_n      <= 1'b1;
		end else if (i_ce) begin
			link_up_reg  <= i_link_up;
			int_stat_reg <= (int_stat_reg & ~stat_clear) | int_event;
			o_int_n      <= ~|(((int_stat_reg & ~stat_clear) | int_event) & int_mask_reg);
		end
	end

	// Register read port, one cycle latency; unmapped offsets read zero
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mgmt_rdata  <= pmsc_pkg::REG_ZERO;
			o_mgmt_rvalid <= 1'b0;
		end else if (i_ce) begin
			o_mgmt_rvalid <= i_mgmt_rd;
			if (i_mgmt_rd) begin
				case (i_mgmt_addr)
					pmsc_pkg::ADDR_MODE_CONFIG_ONE:  o_mgmt_rdata <= cfg_one_reg;
					pmsc_pkg::ADDR_MODE_CONFIG_FOUR: o_mgmt_rdata <= cfg_four_reg;
					pmsc_pkg::ADDR_INT_MASK_CONTROL: o_mgmt_rdata <= 16'(int_mask_reg);
					pmsc_pkg::ADDR_INT_STATUS:       o_mgmt_rdata <= 16'(int_stat_reg);
					default:                         o_mgmt_rdata <= pmsc_pkg::REG_ZERO;
				endcase
			end
		end
	end

	// Mode outputs: address straps feed only the captured image
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mgmt_addr     <= 4'h0;
			o_rx_skew       <= 3'h0;
			o_tx_skew       <= 2'h0;
			o_aneg_disable  <= 1'b0;
			o_mirror_active <= 1'b0;
			o_speed         <= pmsc_pkg::PMSC_SPD_1000;
		end else if (i_ce) begin
			o_mgmt_addr     <= {latch_reg[1], latch_reg[0]};
			o_rx_skew       <= cfg_four_reg[pmsc_pkg::RX_SKEW_MSB:pmsc_pkg::RX_SKEW_LSB];
			o_tx_skew       <= cfg_four_reg[pmsc_pkg::TX_SKEW_MSB:pmsc_pkg::TX_SKEW_LSB];
			o_aneg_disable  <= cfg_four_reg[pmsc_pkg::ANEG_DIS_BIT];
			o_mirror_active <= mirror_en;
			o_speed         <= speed_reg;
		end
	end

	// MDI/MDIX state does not change the mirror map in either speed
	logic unused_mdix;
	assign unused_mdix = i_mdix;

endmodule
`default_nettype wire

// ===== test/pmsc_top_props.sv
// Port-level checks of the mode control block, attached by bind.
// Assumes the clock enable stays high while these checks are meant to hold.
`timescale 1ns/10ps
`default_nettype none
module pmsc_top_props (
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic        i_ce,
	input wire logic        i_sw_reset,
	input wire logic        i_mgmt_wr,
	input wire logic        i_mgmt_rd,
	input wire logic [7:0]  i_mgmt_addr,
	input wire logic [15:0] o_mgmt_rdata,
	input wire logic        o_mgmt_rvalid,
	input wire logic        i_link_fail,
	input wire logic [2:0]  i_tx_sym_a,
	input wire logic [2:0]  i_tx_sym_d,
	input wire logic [2:0]  o_mdi_sym_a,
	input wire logic [2:0]  o_mdi_sym_d,
	input wire logic        o_clk_out,
	input wire logic [1:0]  o_speed,
	input wire logic        o_mirror_active,
	input wire logic        o_int_n
);
	logic mapped;
	logic cfg_one_wr;

	// Test mode entry turns symbols to pattern one edge before the clock first rises
	assign cfg_one_wr = i_ce && i_mgmt_wr && i_mgmt_addr == pmsc_pkg::ADDR_MODE_CONFIG_ONE;

	// Decoded offset kept apart so the read check can look one cycle back
	assign mapped = i_mgmt_addr inside {pmsc_pkg::ADDR_MODE_CONFIG_ONE,
		pmsc_pkg::ADDR_INT_MASK_CONTROL, pmsc_pkg::ADDR_INT_STATUS,
		pmsc_pkg::ADDR_MODE_CONFIG_FOUR};

	// One clock domain, so clocking and reset are given once
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	// Three steady cycles hide the one-cycle skew between config and symbols
	sequence mir_gig;
		(o_mirror_active && o_speed == 2'h2 && !o_clk_out) [*3] ##0 !$past(cfg_one_wr, 2);
	endsequence
	sequence mir_slow;
		(o_mirror_active && o_speed != 2'h2 && !o_clk_out) [*3] ##0 !$past(cfg_one_wr, 2);
	endsequence
	sequence spd_drop;
		$changed(o_speed) && o_speed != 2'h2;
	endsequence

	rd_answer_a: assert property (i_ce && i_mgmt_rd |=> o_mgmt_rvalid)
		else $error("read strobe not answered one cycle later");
	rd_cause_a: assert property (o_mgmt_rvalid |-> $past(i_ce && i_mgmt_rd))
		else $error("read valid without a read strobe");
	unmapped_zero_a: assert property (o_mgmt_rvalid && !$past(mapped) |-> o_mgmt_rdata == 16'h0000)
		else $error("unmapped read returned nonzero data");
	speed_step_a: assert property (spd_drop |-> $past(i_link_fail, 2) && o_speed == $past(o_speed) - 2'h1)
		else $error("speed dropped without a failed attempt or skipped a step");
	swrst_gig_a: assert property (i_sw_reset |-> ##2 o_speed == 2'h2)
		else $error("software reset did not restore gigabit");
	mirror_gig_a: assert property (mir_gig |-> o_mdi_sym_a == 3'h0 - $past(i_tx_sym_d) && o_mdi_sym_d == 3'h0 - $past(i_tx_sym_a))
		else $error("gigabit mirror mapping wrong");
	mirror_slow_a: assert property (mir_slow |-> o_mdi_sym_d == 3'h0 - $past(i_tx_sym_a) && o_mdi_sym_a == 3'h0)
		else $error("slow speed mirror mapping wrong");
	int_release_a: assert property ($rose(o_int_n) |-> $past(i_mgmt_rd) || $past(i_mgmt_wr, 2))
		else $error("interrupt released without a register access");
	test_clk_a: assert property (o_clk_out |=> !o_clk_out)
		else $error("test clock held high two cycles");
endmodule

bind pmsc_top pmsc_top_props u_props (.i_clk, .i_arst_n, .i_ce, .i_sw_reset, .i_mgmt_wr,
	.i_mgmt_rd, .i_mgmt_addr, .o_mgmt_rdata, .o_mgmt_rvalid, .i_link_fail, .i_tx_sym_a,
	.i_tx_sym_d, .o_mdi_sym_a, .o_mdi_sym_d, .o_clk_out, .o_speed, .o_mirror_active, .o_int_n);
`default_nettype wire

// ===== test/pmsc_link_model.sv
// Behavioural cable partner: failed link attempts, energy and transmit symbols.
// Assumes the bench asks for one failed attempt at a time.
`timescale 1ns/10ps
`default_nettype none
module pmsc_link_model (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_fail_go,
	input  wire logic       i_slow,
	input  wire logic       i_energy,
	output logic            o_link_fail,
	output logic            o_energy_cd,
	output logic      [2:0] o_sym_a,
	output logic      [2:0] o_sym_b,
	output logic      [2:0] o_sym_c,
	output logic      [2:0] o_sym_d
);
	logic       pend;
	logic [2:0] wait_cnt;
	logic [2:0] sym_cnt;

	// A failed attempt after short or long training, one cycle wide
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend <= 1'b0;
			wait_cnt <= 3'h0;
			o_link_fail <= 1'b0;
		end else begin
			o_link_fail <= 1'b0;
			if (i_fail_go) begin
				pend <= 1'b1;
				wait_cnt <= i_slow ? 3'h6 : 3'h1;
			end else if (pend && wait_cnt == 3'h0) begin
				pend <= 1'b0;
				o_link_fail <= 1'b1;
			end else if (pend) begin
				wait_cnt <= wait_cnt - 3'h1;
			end
		end
	end

	// Symbols change every cycle so a stale mapping cannot match by luck
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sym_cnt <= 3'h1;
		end else begin
			sym_cnt <= sym_cnt + 3'h3;
		end
	end

	assign o_sym_a = sym_cnt;
	assign o_sym_b = sym_cnt ^ 3'h1;
	assign o_sym_c = sym_cnt ^ 3'h2;
	assign o_sym_d = ~sym_cnt;
	assign o_energy_cd = i_energy; // Energy on C and D
endmodule
`default_nettype wire

// ===== test/pmsc_tb.sv
// Bench for the mode control block: straps, register port, downshift, test modes.
// Assumes the link model supplies failed attempts and transmit symbols.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        i_clk = 1'b0, i_arst_n = 1'b0, i_ce = 1'b1, i_sw_reset = 1'b0;
	logic [1:0]  i_rx_data_lane0_strap = 2'h1, i_rx_data_lane2_strap = 2'h2;
	logic [1:0]  i_rx_ctrl_strap = 2'h3, i_gp0_strap = 2'h2, i_gp1_strap = 2'h3;
	logic [1:0]  i_indicator2_strap = 2'h1, i_indicator0_strap = 2'h2;
	logic        i_mgmt_wr = 1'b0, i_mgmt_rd = 1'b0;
	logic [7:0]  i_mgmt_addr = 8'h00;
	logic [15:0] i_mgmt_wdata = 16'h0000, o_mgmt_rdata, rd_val;
	logic        o_mgmt_rvalid, i_link_fail, i_link_up = 1'b0, i_energy_cd, i_mdix = 1'b0;
	logic [2:0]  i_tx_sym_a, i_tx_sym_b, i_tx_sym_c, i_tx_sym_d;
	logic [2:0]  o_mdi_sym_a, o_mdi_sym_b, o_mdi_sym_c, o_mdi_sym_d, o_rx_skew;
	logic        o_clk_out, o_aneg_disable, o_mirror_active, o_int_n, c0;
	logic [1:0]  o_speed, o_tx_skew;
	logic [3:0]  o_mgmt_addr;
	logic        fail_go = 1'b0, slow = 1'b0, energy = 1'b1;
	int          mismatches = 0, n_checks = 0;

	pmsc_top DUT (.i_clk, .i_arst_n, .i_ce, .i_sw_reset, .i_rx_data_lane0_strap,
		.i_rx_data_lane2_strap, .i_rx_ctrl_strap, .i_gp0_strap, .i_gp1_strap,
		.i_indicator2_strap, .i_indicator0_strap, .i_mgmt_wr, .i_mgmt_rd, .i_mgmt_addr,
		.i_mgmt_wdata, .o_mgmt_rdata, .o_mgmt_rvalid, .i_link_fail, .i_link_up,
		.i_energy_cd, .i_mdix, .i_tx_sym_a, .i_tx_sym_b, .i_tx_sym_c, .i_tx_sym_d,
		.o_mdi_sym_a, .o_mdi_sym_b, .o_mdi_sym_c, .o_mdi_sym_d, .o_clk_out, .o_speed,
		.o_mgmt_addr, .o_rx_skew, .o_tx_skew, .o_aneg_disable, .o_mirror_active, .o_int_n);

	pmsc_link_model u_link (.i_clk, .i_arst_n, .i_fail_go(fail_go), .i_slow(slow),
		.i_energy(energy), .o_link_fail(i_link_fail), .o_energy_cd(i_energy_cd),
		.o_sym_a(i_tx_sym_a), .o_sym_b(i_tx_sym_b), .o_sym_c(i_tx_sym_c), .o_sym_d(i_tx_sym_d));

	// 250 MHz core clock
	always #2 i_clk = ~i_clk;

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// One word per access; strobe lowered at the edge that takes it
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_mgmt_wr <= 1'b1;
		i_mgmt_addr <= a;
		i_mgmt_wdata <= d;
		@(posedge i_clk);
		i_mgmt_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge i_clk);
		i_mgmt_rd <= 1'b1;
		i_mgmt_addr <= a;
		@(posedge i_clk);
		i_mgmt_rd <= 1'b0;
		#1;
		chk("read valid", 16'h0001, {15'h0, o_mgmt_rvalid});
		rd_val = o_mgmt_rdata;
	endtask

	task swr;
		@(posedge i_clk);
		i_sw_reset <= 1'b1;
		@(posedge i_clk);
		i_sw_reset <= 1'b0;
		tick(3);
	endtask

	// Bounded wait for the partner's failed attempt, then speed settles
	task fail_once(input logic [1:0] exp);
		int k;
		@(posedge i_clk);
		fail_go <= 1'b1;
		@(posedge i_clk);
		fail_go <= 1'b0;
		for (k = 0; k < 20 && i_link_fail !== 1'b1; k++)
			@(negedge i_clk);
		if (i_link_fail !== 1'b1) begin
			mismatches++;
			end_sim;
		end
		tick(3);
		chk("speed", {14'h0, exp}, {14'h0, o_speed});
	endtask

	initial begin
		repeat (20) @(posedge i_clk);
		i_arst_n <= 1'b1;
		tick(16);
		chk("mgmt addr", 16'h0009, {12'h0, o_mgmt_addr});
		chk("rx skew", 16'h0007, {13'h0, o_rx_skew});
		chk("tx skew", 16'h0001, {14'h0, o_tx_skew});
		chk("aneg off", 16'h0001, {15'h0, o_aneg_disable});
		chk("mirror", 16'h0001, {15'h0, o_mirror_active});
		rd(pmsc_pkg::ADDR_MODE_CONFIG_FOUR);
		chk("cfg four", 16'h10bb, rd_val);
		// Pins move after capture; nothing may follow them
		@(posedge i_clk);
		{i_rx_data_lane0_strap, i_rx_data_lane2_strap, i_rx_ctrl_strap} <= 6'h00;
		{i_gp0_strap, i_gp1_strap, i_indicator2_strap, i_indicator0_strap} <= 8'h00;
		wr(pmsc_pkg::ADDR_MODE_CONFIG_FOUR, 16'h0000);
		tick(2);
		chk("override mirror", 16'h0000, {15'h0, o_mirror_active});
		chk("override skew", 16'h0000, {13'h0, o_rx_skew});
		swr();
		rd(pmsc_pkg::ADDR_MODE_CONFIG_FOUR);
		chk("reload", 16'h10bb, rd_val);
		chk("mgmt addr held", 16'h0009, {12'h0, o_mgmt_addr});
		// Downshift off by default: failures change nothing
		repeat (5) fail_once(2'h2);
		wr(pmsc_pkg::ADDR_INT_MASK_CONTROL, 16'h0007);
		rd(pmsc_pkg::ADDR_INT_MASK_CONTROL);
		chk("mask", 16'h0007, rd_val);
		rd(pmsc_pkg::ADDR_INT_STATUS);
		wr(pmsc_pkg::ADDR_MODE_CONFIG_FOUR, 16'h11bb);
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			fail_once(i < 3 ? 2'h2 : 2'h1);
		end
		chk("int low", 16'h0000, {15'h0, o_int_n});
		rd(pmsc_pkg::ADDR_INT_STATUS);
		chk("status", 16'h0006, rd_val);
		chk("int high", 16'h0001, {15'h0, o_int_n});
		fail_once(2'h0);
		chk("slow mirror a", 16'h0000, {13'h0, o_mdi_sym_a});
		rd(pmsc_pkg::ADDR_INT_STATUS);
		wr(pmsc_pkg::ADDR_INT_STATUS, 16'hffff);
		rd(pmsc_pkg::ADDR_INT_STATUS);
		chk("status ro", 16'h0000, rd_val);
		@(posedge i_clk);
		i_link_up <= 1'b1;
		rd(pmsc_pkg::ADDR_INT_STATUS);
		chk("link event", 16'h0001, rd_val);
		@(posedge i_clk);
		i_link_up <= 1'b0;
		rd(8'h20);
		chk("unmapped", 16'h0000, rd_val);
		swr();
		wr(pmsc_pkg::ADDR_MODE_CONFIG_FOUR, 16'h09bb);
		fail_once(2'h2);
		fail_once(2'h1);
		swr();
		energy <= 1'b0;
		wr(pmsc_pkg::ADDR_MODE_CONFIG_FOUR, 16'h13bb);
		fail_once(2'h1);
		swr();
		energy <= 1'b1;
		// Gigabit mirror with reversed polarity, against the symbol one cycle back
		@(negedge i_clk);
		c0 = 1'b0;
		rd_val = {13'h0, 3'h0 - i_tx_sym_a};
		tick(1);
		chk("gig mirror d", rd_val, {13'h0, o_mdi_sym_d});
		for (int m = 1; m < 5; m++) begin
			wr(pmsc_pkg::ADDR_MODE_CONFIG_ONE, {3'(m), 13'h0});
			rd(pmsc_pkg::ADDR_MODE_CONFIG_ONE);
			chk("test mode", {3'(m), 13'h0}, rd_val);
			tick(2);
			c0 = o_clk_out;
			tick(1);
			chk("test clock", 16'h0001, {15'h0, c0 ^ o_clk_out});
			chk("pattern", 16'h0001, {15'h0, o_mdi_sym_a === pmsc_pkg::SYM_POS2 ||
				o_mdi_sym_a === pmsc_pkg::SYM_NEG2});
		end
		wr(pmsc_pkg::ADDR_MODE_CONFIG_ONE, 16'h0000);
		tick(3);
		chk("normal clock", 16'h0000, {15'h0, o_clk_out});
		// Second hardware reset with all straps left open
		@(posedge i_clk);
		i_arst_n <= 1'b0;
		tick(3);
		@(posedge i_clk);
		i_arst_n <= 1'b1;
		tick(16);
		chk("open addr", 16'h0000, {12'h0, o_mgmt_addr});
		rd(pmsc_pkg::ADDR_MODE_CONFIG_FOUR);
		chk("open cfg four", 16'h1000, rd_val);
		end_sim;
	end
endmodule
`default_nettype wire
